/* File: rdp_defines.svh */
// Constants of the serial data readout port: sizes, timing and reset values.
`ifndef RDP_DEFINES_SVH
`define RDP_DEFINES_SVH

// Buffer size in bits and width of its pointers and fill count.
`define RDP_BUF_DEPTH 128
`define RDP_PTR_W 7
`define RDP_CNT_W 8

// Core clock period.
`define RDP_CLK_PERIOD_NS 10

// Ready check delay, a longest time, rounded down to cycles.
`define RDP_READY_CHECK_NS 750
`define RDP_READY_CHECK_CYC (`RDP_READY_CHECK_NS / `RDP_CLK_PERIOD_NS)

// Least high and low widths of the data clock, rounded up to cycles.
`define RDP_CLOCK_HIGH_WIDTH_NS 750
`define RDP_CLOCK_HIGH_CYC ((`RDP_CLOCK_HIGH_WIDTH_NS + `RDP_CLK_PERIOD_NS - 1) / `RDP_CLK_PERIOD_NS)
`define RDP_CLOCK_LOW_WIDTH_NS 750
`define RDP_CLOCK_LOW_CYC ((`RDP_CLOCK_LOW_WIDTH_NS + `RDP_CLK_PERIOD_NS - 1) / `RDP_CLK_PERIOD_NS)

// Mode switch window given to the controller, for reference only.
`define RDP_MODE_SWITCH_US 840

// Reset values.
`define RDP_RST_BIT 1'b0
`define RDP_RST_CNT 8'h00
`define RDP_RST_PTR 7'h00
`define RDP_RST_TMR 8'h00

`endif

/* File: rdp_pkg.sv */
// Types of the serial data readout port.
`include "rdp_defines.svh"

package rdp_pkg;

  // Operating mode, coded as {test select, mode select}.
  typedef enum logic [1:0]
  {
    RDP_MD_MASTER = 2'b00,
    RDP_MD_SLAVE = 2'b01,
    RDP_MD_STANDBY = 2'b10,
    RDP_MD_TEST = 2'b11
  } rdp_mode_e;

  // Master clock generator states.
  typedef enum logic [1:0]
  {
    RDP_MS_IDLE = 2'b00,
    RDP_MS_HIGH = 2'b01,
    RDP_MS_LOW = 2'b10,
    RDP_MS_HOLD = 2'b11
  } rdp_mst_e;

  // Whole state of the core clock domain.
  typedef struct packed
  {
    logic mode_s1;
    logic mode_s2;
    logic test_s1;
    logic test_s2;
    logic clr_s1;
    logic clr_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_seen;
    logic self_pend;
    logic armed;
    logic reliability_flag;
    logic ready;
    logic dout;
    logic clk_o;
    rdp_mst_e mst;
    logic [7:0] tmr;
    logic [`RDP_PTR_W-1:0] wr_ptr;
    logic [`RDP_PTR_W-1:0] rd_ptr;
    logic [`RDP_CNT_W-1:0] count;
    logic [`RDP_BUF_DEPTH-1:0] mem;
  } rdp_core_s;

  // Whole state of the link clock domain.
  typedef struct packed
  {
    logic tog;
  } rdp_link_s;

endpackage

/* File: rdp_readout.sv */
// Serial data readout port with master and slave readout over a bit buffer.
`timescale 1ns/100ps
`default_nettype none
`include "rdp_defines.svh"

module rdp_readout
#(
  parameter int unsigned MST_HIGH_CYC = `RDP_CLOCK_HIGH_CYC,
  parameter int unsigned MST_LOW_CYC = `RDP_CLOCK_LOW_CYC
)
(
  // Core clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Static select pins and clear pin.
  input wire logic test_sel_pin,
  input wire logic mode_sel_pin,
  input wire logic clear_pin,
  // Data clock pin, two-way; its input also clocks the link logic.
  input wire logic data_clock_i,
  output logic data_clock_o,
  output logic data_clock_oe,
  // Serial data pin.
  output logic serial_data_pin,
  // Shared status pin, open drain.
  output logic shared_status_o,
  output logic shared_status_oe,
  // Decoder side: decoded bits and reliability detector.
  input wire logic dec_bit,
  input wire logic dec_valid,
  input wire logic rel_detect,
  // Status toward the rest of the chip.
  output logic osc_halt,
  output logic demod_clear,
  output rdp_pkg::rdp_mode_e mode
);
  import rdp_pkg::*;

  rdp_core_s r_reg;
  rdp_core_s r_next;
  rdp_link_s l_reg;
  rdp_link_s l_next;
  logic pop;
  logic wr;
  logic mst_pop;
  logic slv_clear;

  // Link domain: every falling data clock edge flips a toggle for the core.
  always_comb
  begin
    l_next = l_reg;
    l_next.tog = ~l_reg.tog;
  end

  always_ff @(negedge data_clock_i or negedge resetn)
  begin
    if (!resetn)
      l_reg <= '0;
    else
      l_reg <= l_next;
  end

  // Mode decode from the synchronised select pins.
  assign mode = rdp_mode_e'({r_reg.test_s2, r_reg.mode_s2});

  // Core domain next-state logic.
  always_comb
  begin
    r_next = r_reg;
    pop = 1'b0;
    mst_pop = 1'b0;
    // Two-flop synchronisers for pins and the link toggle.
    r_next.mode_s1 = mode_sel_pin;
    r_next.mode_s2 = r_reg.mode_s1;
    r_next.test_s1 = test_sel_pin;
    r_next.test_s2 = r_reg.test_s1;
    r_next.clr_s1 = clear_pin;
    r_next.clr_s2 = r_reg.clr_s1;
    r_next.tog_s1 = l_reg.tog;
    r_next.tog_s2 = r_reg.tog_s1;
    slv_clear = r_reg.clr_s2 && (mode == RDP_MD_SLAVE);
    // Reliability detector: cleared while clear is high, arms on first detection.
    if (r_reg.clr_s2)
    begin
      r_next.reliability_flag = 1'b0;
      r_next.armed = 1'b0;
    end
    else
    begin
      r_next.reliability_flag = rel_detect;
      if (rel_detect)
        r_next.armed = 1'b1;
    end
    // Storage only once armed, never over unread bits.
    wr = dec_valid && r_reg.armed && !slv_clear
      && (r_reg.count != `RDP_CNT_W'(`RDP_BUF_DEPTH));
    // A falling edge the core drove itself is not a slave read.
    if (r_reg.tog_s2 != r_reg.tog_seen)
    begin
      r_next.tog_seen = r_reg.tog_s2;
      if (r_reg.self_pend)
        r_next.self_pend = 1'b0;
      else if ((mode == RDP_MD_SLAVE) && (r_reg.count != `RDP_RST_CNT))
        pop = 1'b1;
    end
    // Master clock generator: data changes with the rising edge.
    if (mode == RDP_MD_MASTER)
    begin
      case (r_reg.mst)
        RDP_MS_HOLD:
        begin
          r_next.clk_o = 1'b1;
          r_next.dout = 1'b1;
          if (r_reg.armed && !r_reg.clr_s2)
          begin
            r_next.clk_o = 1'b0;
            r_next.self_pend = 1'b1;
            r_next.mst = RDP_MS_IDLE;
          end
        end
        RDP_MS_IDLE:
        begin
          if (r_reg.count != `RDP_RST_CNT)
          begin
            mst_pop = 1'b1;
            r_next.dout = r_reg.mem[r_reg.rd_ptr];
            r_next.clk_o = 1'b1;
            r_next.tmr = `RDP_RST_TMR;
            r_next.mst = RDP_MS_HIGH;
          end
        end
        RDP_MS_HIGH:
        begin
          r_next.tmr = r_reg.tmr + 8'h01;
          if (r_reg.tmr == 8'(MST_HIGH_CYC - 1))
          begin
            r_next.clk_o = 1'b0;
            r_next.self_pend = 1'b1;
            r_next.tmr = `RDP_RST_TMR;
            r_next.mst = RDP_MS_LOW;
          end
        end
        RDP_MS_LOW:
        begin
          r_next.tmr = r_reg.tmr + 8'h01;
          if (r_reg.tmr == 8'(MST_LOW_CYC - 1))
            r_next.mst = RDP_MS_IDLE;
        end
        default:
        begin
          r_next.mst = RDP_MS_IDLE;
        end
      endcase
      // Clear in master mode holds clock and data high until detection.
      if (r_reg.clr_s2)
      begin
        mst_pop = 1'b0;
        r_next.clk_o = 1'b1;
        r_next.dout = 1'b1;
        r_next.mst = RDP_MS_HOLD;
      end
    end
    else
    begin
      r_next.mst = RDP_MS_IDLE;
      r_next.clk_o = 1'b0;
    end
    // Buffer update: both modes read the same store; a bit popped in the master high phase is lost if the mode changes to slave then.
    if (pop || mst_pop)
      r_next.rd_ptr = r_reg.rd_ptr + `RDP_PTR_W'(1);
    if (wr)
    begin
      r_next.mem[r_reg.wr_ptr] = dec_bit;
      r_next.wr_ptr = r_reg.wr_ptr + `RDP_PTR_W'(1);
    end
    if (wr && !(pop || mst_pop))
      r_next.count = r_reg.count + 8'h01;
    else if (!wr && (pop || mst_pop))
      r_next.count = r_reg.count - 8'h01;
    if (slv_clear)
    begin
      r_next.rd_ptr = `RDP_RST_PTR;
      r_next.wr_ptr = `RDP_RST_PTR;
      r_next.count = `RDP_RST_CNT;
    end
    // Slave data shows the buffer head, stable between falling edges.
    if ((mode == RDP_MD_SLAVE) && (r_next.count != `RDP_RST_CNT))
      r_next.dout = r_next.mem[r_next.rd_ptr];
    // Ready follows the fill level, only after the first detection.
    r_next.ready = (mode == RDP_MD_SLAVE) && r_next.armed
      && (r_next.count != `RDP_RST_CNT);
  end

  // Core domain state register.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // Pin drivers; in standby and test the shared pins are released.
  assign data_clock_o = r_reg.clk_o;
  assign data_clock_oe = (mode == RDP_MD_MASTER);
  assign serial_data_pin = r_reg.dout;
  assign shared_status_o = 1'b0;
  assign shared_status_oe = ((mode == RDP_MD_MASTER) && !r_reg.reliability_flag)
    || ((mode == RDP_MD_SLAVE) && !r_reg.ready);
  assign osc_halt = (mode == RDP_MD_STANDBY);
  assign demod_clear = r_reg.clr_s2;

  // Master mode drives the data clock, slave mode releases it.
  property p_master_drive;
    @(posedge ref_clk) disable iff (!resetn)
    (mode == RDP_MD_MASTER) |-> data_clock_oe && (shared_status_oe == !r_reg.reliability_flag);
  endproperty
  master_clock_drive_a: assert property (p_master_drive)
    else $error("Master mode does not drive the data clock or flag.");

  slave_clock_input_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (mode == RDP_MD_SLAVE) |-> !data_clock_oe && (shared_status_oe == !r_reg.ready))
    else $error("Slave mode drives the data clock or misreports ready.");

  standby_oscillator_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (mode == RDP_MD_STANDBY) |-> osc_halt && !data_clock_oe && !shared_status_oe)
    else $error("Standby does not halt the oscillator or release pins.");

  slave_clear_empty_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (r_reg.clr_s2 && (mode == RDP_MD_SLAVE)) |=> (r_reg.count == 8'h00) && !r_reg.ready)
    else $error("Clear in slave mode leaves buffer or ready set.");

  master_hold_high_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ((mode == RDP_MD_MASTER) && r_reg.clr_s2) ##1 (mode == RDP_MD_MASTER) && !r_reg.armed
    |-> r_reg.clk_o && r_reg.dout)
    else $error("Master outputs not held high after clear.");

  ready_update_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ((mode == RDP_MD_SLAVE) && $changed(r_reg.tog_s2))
    |-> ##[1:3] (r_reg.ready == (r_reg.armed && (r_reg.count != 8'h00))))
    else $error("Ready not updated after a falling data clock edge.");

  no_store_unarmed_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !r_reg.armed |=> (r_reg.count <= $past(r_reg.count)) && !r_reg.ready)
    else $error("Data stored or ready raised before first detection.");

  keep_storing_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (r_reg.armed && dec_valid && !rel_detect && !r_reg.clr_s2 && !pop && !mst_pop
      && (r_reg.count < 8'h80)) |=> (r_reg.count == $past(r_reg.count) + 8'h01))
    else $error("Decoded bit dropped after first detection.");

  full_discard_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ((r_reg.count == 8'h80) && dec_valid && !pop && !mst_pop && !r_reg.clr_s2)
    |=> (r_reg.count == 8'h80) && $stable(r_reg.wr_ptr))
    else $error("Full buffer overwritten by a new bit.");

  master_rise_data_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ((r_reg.mst == RDP_MS_HIGH) && (mode == RDP_MD_MASTER) && !r_reg.clr_s2)
    |=> $stable(r_reg.dout) && ((r_reg.mst == RDP_MS_LOW) || r_reg.clk_o))
    else $error("Master data changed away from the rising clock edge.");

endmodule
`default_nettype wire

/* File: rdp_mcu_model.sv */
// Controller model that reads the serial data stream in slave readout.
`timescale 1ns/100ps
`default_nettype none

module rdp_mcu_model
(
  // Link reference clock and enable.
  input wire logic lclk,
  input wire logic en,
  // Pins seen from the controller.
  input wire logic ready,
  input wire logic sdata,
  output logic dclk,
  // Received bits and their count.
  output logic [7:0] got,
  output logic [7:0] nbits
);
  initial
  begin
    dclk = 1'b0;
    got = 8'h00;
    nbits = 8'h00;
  end

  // One read cycle per pass; the clock stands low while ready is low.
  always
  begin
    @(posedge lclk);
    if (en && ready)
    begin
      dclk = 1'b1;
      got = {got[6:0], sdata};
      nbits = nbits + 8'h01;
      repeat (25) @(posedge lclk);
      dclk = 1'b0;
      // Low for at least 832 ns, longer than the ready check delay.
      repeat (25) @(posedge lclk);
    end
  end
endmodule

`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench of the serial data readout port.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import rdp_pkg::*;
  logic ref_clk = 1'b0;
  logic lclk = 1'b0;
  logic resetn = 1'b0;
  logic test_sel = 1'b0;
  logic mode_sel = 1'b0;
  logic clear = 1'b0;
  logic dec_bit = 1'b0;
  logic dec_valid = 1'b0;
  logic rel_detect = 1'b0;
  logic mcu_en = 1'b0;
  logic cap_on = 1'b0;
  logic dclk_o, dclk_oe, sdata, st_o, st_oe, osc_halt, demod_clear, mcu_clk, dclk_w, st_lvl;
  rdp_mode_e mode;
  logic [7:0] got, nbits, mgot, mcnt, base;
  int failures = 0;
  int total_checks = 0;

  // Core clock, and an unrelated link reference for the controller.
  always #5 ref_clk = ~ref_clk;
  initial #3 forever #16 lclk = ~lclk;

  // Pin levels: driven clock, and status pin with pull-up.
  assign dclk_w = dclk_oe ? dclk_o : mcu_clk;
  assign st_lvl = !st_oe;

  rdp_readout #(.MST_HIGH_CYC(4), .MST_LOW_CYC(4)) u_dut
  (
    .ref_clk(ref_clk), .resetn(resetn), .test_sel_pin(test_sel), .mode_sel_pin(mode_sel),
    .clear_pin(clear), .data_clock_i(dclk_w), .data_clock_o(dclk_o), .data_clock_oe(dclk_oe),
    .serial_data_pin(sdata), .shared_status_o(st_o), .shared_status_oe(st_oe),
    .dec_bit(dec_bit), .dec_valid(dec_valid), .rel_detect(rel_detect),
    .osc_halt(osc_halt), .demod_clear(demod_clear), .mode(mode)
  );

  rdp_mcu_model u_mcu
  (
    .lclk(lclk), .en(mcu_en), .ready(st_lvl), .sdata(sdata), .dclk(mcu_clk),
    .got(got), .nbits(nbits)
  );

  initial
  begin
    mgot = 8'h00;
    mcnt = 8'h00;
  end

  // Master capture on the falling edge of the device clock.
  always @(negedge dclk_w)
  begin
    if (cap_on && dclk_oe)
    begin
      mgot = {mgot[6:0], sdata};
      mcnt = mcnt + 8'h01;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Hands eight decoded bits to the port, first bit first.
  task automatic push(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      dec_valid = 1'b1;
      dec_bit = v[i];
      cyc(1);
    end
    dec_valid = 1'b0;
  endtask

  task automatic wait_bits(input logic [7:0] n);
    for (int i = 0; i < 20000 && nbits !== n; i++) cyc(1);
  endtask

  task automatic s_master();
    chk({mode, dclk_oe, st_lvl}, {RDP_MD_MASTER, 2'b10});
    push(8'h01);
    rel_detect = 1'b1;
    cap_on = 1'b1;
    cyc(1);
    rel_detect = 1'b0;
    cyc(3);
    push(8'ha5);
    for (int i = 0; i < 500 && mcnt !== 8'h08; i++) cyc(1);
    chk(mgot, 8'ha5);
    cap_on = 1'b0;
  endtask

  task automatic s_clear_master();
    clear = 1'b1;
    cyc(5);
    chk({7'h00, demod_clear}, 8'h01);
    clear = 1'b0;
    cyc(10);
    chk({6'h00, dclk_o, sdata}, 8'h03);
    rel_detect = 1'b1;
    cyc(4);
    rel_detect = 1'b0;
    cyc(20);
  endtask

  // Master to slave in mid-stream, then back to master, with no bit lost.
  task automatic s_handover();
    cap_on = 1'b1;
    push(8'hc3);
    for (int i = 0; i < 500 && mcnt !== 8'h0c; i++) cyc(1);
    mode_sel = 1'b1;
    mcu_en = 1'b1;
    chk(mgot, 8'h5c);
    base = nbits;
    wait_bits(base + 8'h04);
    chk({4'h0, got[3:0]}, 8'h03);
    cyc(100);
    chk({7'h00, st_lvl}, 8'h00);
    mcu_en = 1'b0;
    mode_sel = 1'b0;
    cyc(8);
    push(8'h69);
    for (int i = 0; i < 500 && mcnt !== 8'h14; i++) cyc(1);
    chk(mgot, 8'h69);
    cap_on = 1'b0;
  endtask

  // Fills the buffer past its size, then flushes it with a clear pulse.
  task automatic s_full();
    mcu_en = 1'b0;
    cyc(200);
    for (int i = 0; i < 17; i++) push(8'h00);
    cyc(4);
    chk({7'h00, st_lvl}, 8'h01);
    clear = 1'b1;
    cyc(5);
    clear = 1'b0;
    cyc(4);
    chk({7'h00, st_lvl}, 8'h00);
  endtask

  task automatic s_standby();
    test_sel = 1'b1;
    cyc(4);
    chk({osc_halt, dclk_oe, st_oe, mode}, {3'b100, RDP_MD_STANDBY});
    test_sel = 1'b0;
    cyc(4);
  endtask

  task automatic s_slave();
    mode_sel = 1'b1;
    mcu_en = 1'b1;
    cyc(4);
    chk({mode, dclk_oe}, {RDP_MD_SLAVE, 1'b0});
    base = nbits;
    push(8'h3c);
    wait_bits(base + 8'h08);
    chk(got, 8'h3c);
    cyc(100);
    chk({7'h00, st_lvl}, 8'h00);
  endtask

  task automatic s_clear_slave();
    mcu_en = 1'b0;
    push(8'hff);
    cyc(4);
    chk({7'h00, st_lvl}, 8'h01);
    clear = 1'b1;
    cyc(5);
    chk({7'h00, st_lvl}, 8'h00);
    clear = 1'b0;
    cyc(4);
    push(8'h0f);
    cyc(4);
    chk({7'h00, st_lvl}, 8'h00);
    rel_detect = 1'b1;
    cyc(1);
    rel_detect = 1'b0;
    cyc(3);
    push(8'h96);
    base = nbits;
    mcu_en = 1'b1;
    wait_bits(base + 8'h08);
    chk(got, 8'h96);
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog against a hang.
  initial
  begin
    #100000;
    failures++;
    complete_run();
  end

  // Main sequence.
  initial
  begin
    cyc(6);
    resetn = 1'b1;
    cyc(4);
    s_master();
    s_handover();
    s_clear_master();
    s_standby();
    s_slave();
    s_clear_slave();
    s_full();
    complete_run();
  end
endmodule

`default_nettype wire
